// ### hdl/udc_defines.svh
// Constants of the DMA completion interrupt block: offsets, fields, reset values.
// Included by the package and by every design file that decodes registers.
`ifndef UDC_DEFINES_SVH
`define UDC_DEFINES_SVH

// Byte offsets of the registers on the APB window.
`define UDC_OFS_IRQ_ACK 12'h000
`define UDC_OFS_MASKED 12'h004
`define UDC_OFS_RAW 12'h008
`define UDC_OFS_EN_SET 12'h00C
`define UDC_OFS_EN_CLR 12'h010
`define UDC_OFS_RX_CTRL 12'h014
`define UDC_OFS_EVT_STAT 12'h018
`define UDC_OFS_EVT_MASK 12'h01C

// Field layout.
`define UDC_ADDR_W 12
`define UDC_DATA_W 32
`define UDC_CHANNELS 4
`define UDC_VEC_W 8
`define UDC_RX_ON_BIT 0
`define UDC_EVT_ACK_BIT 4
`define UDC_EVT_ERR_BIT 5
`define UDC_EVT_W 6

// Reset values and the acknowledging vector.
`define UDC_RST_CHAN 4'h0
`define UDC_RST_VEC 8'h00
`define UDC_RST_EVT 6'h00
`define UDC_ACK_VECTOR 8'h00

`endif

// ### hdl/udc_pkg.sv
// Types shared by the DMA completion interrupt block.
// Assumes udc_defines.svh is on the include path.
`include "udc_defines.svh"

package udc_pkg;
  typedef logic [`UDC_CHANNELS-1:0] udc_chan_t;
  typedef logic [`UDC_ADDR_W-1:0] udc_addr_t;
  typedef logic [`UDC_DATA_W-1:0] udc_word_t;
  typedef logic [`UDC_EVT_W-1:0] udc_evt_t;
  // DMA interrupt line states, Gray coded along idle, raised, gap.
  typedef enum logic [1:0] {
    UDC_IDLE = 2'b00,
    UDC_RAISED = 2'b01,
    UDC_GAP = 2'b11
  } udc_state_e;
endpackage

// ### hdl/udc_reg_if.sv
// Register access strobes passed from the APB slave to the register core.
// Assumes both ends run on the same pclk.
`timescale 1ns/100ps
`default_nettype none

interface udc_reg_if;
  logic setup;
  logic commit;
  logic write;
  udc_pkg::udc_addr_t addr;
  udc_pkg::udc_word_t wdata;
  udc_pkg::udc_word_t rdata;
  logic hit;
  // The bus end decodes phases; the core end answers with data and a hit.
  modport bus (output setup, commit, write, addr, wdata, input rdata, hit);
  modport core (input setup, commit, write, addr, wdata, output rdata, hit);
endinterface

`default_nettype wire

// ### hdl/udc_apb_slave.sv
// APB slave front end with one wait-free access cycle and registered answers.
// Assumes an APB master that holds the request until pready is sampled high.
`timescale 1ns/100ps
`default_nettype none

module udc_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire udc_pkg::udc_addr_t paddr,
  input wire udc_pkg::udc_word_t pwdata,
  output udc_pkg::udc_word_t prdata,
  output logic pready,
  output logic pslverr,
  udc_reg_if.bus rif
);
  import udc_pkg::*;

  udc_word_t prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // The setup cycle is sampled here; the answer is ready in the first access cycle.
  assign rif.setup = psel & ~penable;
  assign rif.commit = psel & penable & pready_reg;
  assign rif.write = pwrite;
  assign rif.addr = paddr;
  assign rif.wdata = pwdata;

  // Read data is captured at the setup edge so that the answer leaves a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= rif.setup;
      pslverr_reg <= rif.setup & ~rif.hit;
      if (rif.setup) begin
        prdata_reg <= (rif.write | ~rif.hit) ? 32'h00000000 : rif.rdata;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule

`default_nettype wire

// ### hdl/udc_irq_ctrl.sv
// DMA transmit completion interrupt controller with APB registers.
// Assumes completion and acknowledge strobes from the DMA engine on pclk.
//
// Notes on behaviour
// - Writing zero to the acknowledge vector ends service of the DMA interrupt.
// - Four raw completion flags, one per channel, set when a packet is sent.
// - Masked completion bits are raw flags ANDed with the enable bits.
// - Four enable bits gate the matching channel's completion flag.
// - A one written to the enable-clear register clears that enable bit.
// - Receive DMA control bit zero turns the receive DMA off or on.
// - A one written to the enable-set register sets that enable bit.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "udc_defines.svh"

module udc_irq_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire udc_pkg::udc_addr_t paddr,
  input wire udc_pkg::udc_word_t pwdata,
  output udc_pkg::udc_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire udc_pkg::udc_chan_t tx_done_evt,
  input wire udc_pkg::udc_chan_t tx_done_ack,
  output logic dma_irq,
  output logic rx_dma_on,
  output logic irq
);
  import udc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end.

  udc_reg_if rif();

  udc_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  udc_chan_t raw_reg;
  udc_chan_t raw_next;
  udc_chan_t raw_keep;
  udc_chan_t enable_reg;
  udc_chan_t enable_next;
  udc_chan_t masked;
  udc_chan_t wdata_lo;
  logic [`UDC_VEC_W-1:0] vector_reg;
  logic rx_on_reg;
  udc_evt_t evt_reg;
  udc_evt_t evt_next;
  udc_evt_t evt_set;
  udc_evt_t evt_shot_reg;
  udc_evt_t evt_mask_reg;
  udc_state_e state_reg;
  udc_state_e state_next;
  logic dma_irq_reg;
  logic irq_reg;
  logic sel_ack, sel_msk, sel_raw, sel_set, sel_clr, sel_rx, sel_evt, sel_emask;
  logic wr_ack, wr_set, wr_clr, wr_rx, wr_emask, rd_evt;
  logic eoi_req;
  logic err_evt;
  logic any_masked;
  udc_word_t masked_word;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and write strobes.

  // Address is stable from setup through the access cycle, so one decode serves both.
  assign sel_ack = rif.addr == `UDC_OFS_IRQ_ACK;
  assign sel_msk = rif.addr == `UDC_OFS_MASKED;
  assign sel_raw = rif.addr == `UDC_OFS_RAW;
  assign sel_set = rif.addr == `UDC_OFS_EN_SET;
  assign sel_clr = rif.addr == `UDC_OFS_EN_CLR;
  assign sel_rx = rif.addr == `UDC_OFS_RX_CTRL;
  assign sel_evt = rif.addr == `UDC_OFS_EVT_STAT;
  assign sel_emask = rif.addr == `UDC_OFS_EVT_MASK;
  assign rif.hit = sel_ack | sel_msk | sel_raw | sel_set | sel_clr | sel_rx | sel_evt | sel_emask;

  // Writes take effect only on the completing access edge.
  assign wr_ack = rif.commit & rif.write & sel_ack;
  assign wr_set = rif.commit & rif.write & sel_set;
  assign wr_clr = rif.commit & rif.write & sel_clr;
  assign wr_rx = rif.commit & rif.write & sel_rx;
  assign wr_emask = rif.commit & rif.write & sel_emask;
  assign rd_evt = rif.commit & ~rif.write & sel_evt;
  assign err_evt = rif.commit & ~rif.hit;
  assign wdata_lo = rif.wdata[`UDC_CHANNELS-1:0];

  // Only a zero vector acknowledges; other values are stored but start nothing.
  assign eoi_req = wr_ack & (rif.wdata[`UDC_VEC_W-1:0] == `UDC_ACK_VECTOR);

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel completion flags and enables.

  // A completion in the same cycle as its acknowledge keeps the flag set.
  genvar ch;
  generate
    for (ch = 0; ch < `UDC_CHANNELS; ch = ch + 1) begin : g_chan
      assign raw_keep[ch] = raw_reg[ch] & ~tx_done_ack[ch];
      assign raw_next[ch] = tx_done_evt[ch] | raw_keep[ch];
      assign enable_next[ch] = (wr_set & wdata_lo[ch]) ? 1'b1 :
                               (wr_clr & wdata_lo[ch]) ? 1'b0 :
                               enable_reg[ch];
      assign masked[ch] = raw_reg[ch] & enable_reg[ch];
    end
  endgenerate

  assign any_masked = |masked;
  assign masked_word = {{(`UDC_DATA_W-`UDC_CHANNELS){1'b0}}, masked};

  // Completion flags, enables and the stored acknowledge vector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_reg <= `UDC_RST_CHAN;
      enable_reg <= `UDC_RST_CHAN;
      vector_reg <= `UDC_RST_VEC;
    end else begin
      raw_reg <= raw_next;
      enable_reg <= enable_next;
      if (wr_ack) begin
        vector_reg <= rif.wdata[`UDC_VEC_W-1:0];
      end
    end
  end

  // Receive DMA enable; software must have built its descriptors first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_on_reg <= 1'b0;
    end else if (wr_rx) begin
      rx_on_reg <= rif.wdata[`UDC_RX_ON_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA interrupt line.

  // The gap state drops the line for one cycle after an acknowledge, so an edge
  // sensitive interrupt controller sees a fresh edge when work is still pending.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      UDC_IDLE: begin
        if (any_masked) state_next = UDC_RAISED;
      end
      UDC_RAISED: begin
        if (eoi_req) state_next = UDC_GAP;
        else if (!any_masked) state_next = UDC_IDLE;
      end
      UDC_GAP: begin
        state_next = any_masked ? UDC_RAISED : UDC_IDLE;
      end
      default: begin
        state_next = UDC_IDLE;
      end
    endcase
  end

  // The line leaves a flop; it lags the masked bits by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= UDC_IDLE;
      dma_irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      dma_irq_reg <= state_next == UDC_RAISED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and summary interrupt.

  assign evt_set = {err_evt, eoi_req, tx_done_evt};
  // Only bits that were returned to software are cleared, and a new event wins.
  assign evt_next = evt_set | (evt_reg & ~(rd_evt ? evt_shot_reg : `UDC_RST_EVT));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= `UDC_RST_EVT;
      evt_shot_reg <= `UDC_RST_EVT;
      evt_mask_reg <= `UDC_RST_EVT;
      irq_reg <= 1'b0;
    end else begin
      evt_reg <= evt_next;
      if (rif.setup & sel_evt & ~rif.write) begin
        evt_shot_reg <= evt_reg;
      end
      if (wr_emask) begin
        evt_mask_reg <= rif.wdata[`UDC_EVT_W-1:0];
      end
      irq_reg <= |(evt_reg & evt_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection; write-only style registers read back the enables.

  assign rif.rdata = sel_ack ? {{(`UDC_DATA_W-`UDC_VEC_W){1'b0}}, vector_reg} :
                     sel_msk ? masked_word :
                     sel_raw ? {{(`UDC_DATA_W-`UDC_CHANNELS){1'b0}}, raw_reg} :
                     (sel_set | sel_clr) ? {{(`UDC_DATA_W-`UDC_CHANNELS){1'b0}}, enable_reg} :
                     sel_rx ? {{(`UDC_DATA_W-1){1'b0}}, rx_on_reg} :
                     sel_evt ? {{(`UDC_DATA_W-`UDC_EVT_W){1'b0}}, evt_reg} :
                     sel_emask ? {{(`UDC_DATA_W-`UDC_EVT_W){1'b0}}, evt_mask_reg} :
                     32'h00000000;

  assign dma_irq = dma_irq_reg;
  assign rx_dma_on = rx_on_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and cover points.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // An acknowledge while raised drops the line in the next cycle.
  AST_EOI_DROPS: assert property (
    (eoi_req && state_reg == UDC_RAISED) |=> !dma_irq)
    else $error("DMA interrupt stayed high after acknowledge.");

  // A completion strobe shows in the raw flags one cycle later.
  AST_RAW_SETS: assert property (
    (tx_done_evt != `UDC_RST_CHAN) |=> ((raw_reg & $past(tx_done_evt)) == $past(tx_done_evt)))
    else $error("Raw completion flag not set by completion.");

  // A flag without acknowledge is kept.
  AST_RAW_HOLDS: assert property (
    (raw_keep != `UDC_RST_CHAN) |=> ((raw_reg & $past(raw_keep)) == $past(raw_keep)))
    else $error("Raw completion flag lost without acknowledge.");

  // A read of the masked register returns raw AND enable from the setup cycle.
  AST_MASKED_READ: assert property (
    (rif.setup && sel_msk && !rif.write) |=> (pready && prdata == $past(masked_word)))
    else $error("Masked status read does not match raw and enable.");

  // Enables held at zero for two cycles keep the DMA line low.
  AST_ENABLE_GATES: assert property (
    (enable_reg == `UDC_RST_CHAN) [*2] |-> !dma_irq)
    else $error("DMA interrupt high with all enables clear.");

  AST_ENABLE_CLR: assert property (
    wr_clr |=> ((enable_reg & $past(wdata_lo)) == `UDC_RST_CHAN))
    else $error("Enable bit not cleared by enable-clear write.");

  AST_ENABLE_SET: assert property (
    wr_set |=> ((enable_reg & $past(wdata_lo)) == $past(wdata_lo)))
    else $error("Enable bit not set by enable-set write.");

  AST_RX_ON: assert property (
    wr_rx |=> (rx_dma_on == $past(rif.wdata[`UDC_RX_ON_BIT])))
    else $error("Receive DMA enable does not follow the written bit.");

  AST_IRQ_RAISE: assert property (
    (any_masked && state_reg != UDC_RAISED) |=> dma_irq)
    else $error("DMA interrupt not raised for a pending masked bit.");

  AST_IRQ_CAUSE: assert property (
    dma_irq |-> $past(any_masked))
    else $error("DMA interrupt raised without a masked bit.");

  // An engine acknowledge with no completion in the same cycle clears the flag.
  AST_RAW_ACK_CLEARS: assert property (
    ((tx_done_ack & ~tx_done_evt) != `UDC_RST_CHAN) |=>
      ((raw_reg & $past(tx_done_ack & ~tx_done_evt)) == `UDC_RST_CHAN))
    else $error("Raw completion flag not cleared by engine acknowledge.");

  // A nonzero vector is only stored, so a raised line with work pending stays up.
  AST_VECTOR_IGNORED: assert property (
    (wr_ack && rif.wdata[`UDC_VEC_W-1:0] != `UDC_ACK_VECTOR && state_reg == UDC_RAISED && any_masked) |=> dma_irq)
    else $error("Nonzero vector write dropped the DMA interrupt.");

  // An unmapped access is answered at once with an error and zero data.
  AST_SLVERR_UNMAPPED: assert property (
    (rif.setup && !rif.hit) |=> (pready && pslverr && prdata == 32'h00000000))
    else $error("Unmapped access not refused with an error.");

  // The summary line follows the unmasked event bits one cycle later.
  AST_IRQ_LEVEL: assert property (
    irq == $past(|(evt_reg & evt_mask_reg)))
    else $error("Summary interrupt does not follow unmasked events.");

  COV_REARM: cover property (eoi_req && any_masked ##1 !dma_irq ##1 dma_irq);
  COV_READ_CLEAR: cover property (rd_evt && evt_shot_reg != `UDC_RST_EVT);
  COV_SLVERR: cover property (pready && pslverr);
  COV_IRQ: cover property ($rose(irq));
endmodule

`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the DMA completion interrupt block, driven over APB.
// Assumes the design files under hdl/ and udc_defines.svh on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "udc_defines.svh"

module tb_top;
  import udc_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  udc_addr_t paddr;
  udc_word_t pwdata;
  udc_word_t prdata;
  logic pready;
  logic pslverr;
  udc_chan_t tx_done_evt;
  udc_chan_t tx_done_ack;
  logic dma_irq;
  logic rx_dma_on;
  logic irq;
  int err_total;
  int cmp_count;
  udc_word_t rd;
  logic er;

  ////////////////////////////////////////////////////////////////////////////
  // Device under test, every input driven by the bench.
  udc_irq_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_done_evt(tx_done_evt), .tx_done_ack(tx_done_ack), .dma_irq(dma_irq), .rx_dma_on(rx_dma_on), .irq(irq));

  // Free-running 50 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compares with case equality so an unknown never passes.
  task automatic chk(input string name, input udc_word_t seen, input udc_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; pready is sampled at the rising edge, where the slave commits.
  // No wait limit here: only the watchdog ends a hung access.
  task automatic xfer(input udc_addr_t a, input logic w, input udc_word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input udc_addr_t a, input udc_word_t d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdchk(input udc_addr_t a, input udc_word_t exp, input string name);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(name, rd, exp);
    chk({name, " error"}, {31'h0, er}, 32'h0000_0000);
  endtask

  // Single place where the run ends.
  task automatic conclude;
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the roughly 130 cycles the sequence needs.
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    conclude;
  end

  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tx_done_evt = 4'h0;
    tx_done_ack = 4'h0;
    err_total = 0;
    cmp_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Every register comes out of reset as zero.
    for (int i = 0; i < 8; i++) begin
      rdchk(12'(i * 4), 32'h0000_0000, "reset value");
    end
    chk("dma_irq at reset", {31'h0, dma_irq}, 32'h0000_0000);
    // An unmapped access is refused and raises event bit 5 behind the mask.
    xfer(12'h020, 1'b0, 32'h0000_0000);
    chk("unmapped data", rd, 32'h0000_0000);
    chk("unmapped error", {31'h0, er}, 32'h0000_0001);
    wr(`UDC_OFS_EVT_MASK, 32'h0000_0020);
    repeat (2) @(negedge pclk);
    chk("irq raised", {31'h0, irq}, 32'h0000_0001);
    rdchk(`UDC_OFS_EVT_STAT, 32'h0000_0020, "event status");
    repeat (2) @(negedge pclk);
    chk("irq after read clear", {31'h0, irq}, 32'h0000_0000);
    // Enable set and clear act only on the bits written as one; upper bits are ignored.
    wr(`UDC_OFS_EN_SET, 32'hFFFF_FFF5);
    rdchk(`UDC_OFS_EN_SET, 32'h0000_0005, "enable after set");
    wr(`UDC_OFS_EN_SET, 32'h0000_000A);
    rdchk(`UDC_OFS_EN_CLR, 32'h0000_000F, "enable all");
    wr(`UDC_OFS_EN_CLR, 32'h0000_0003);
    rdchk(`UDC_OFS_EN_SET, 32'h0000_000C, "enable after clear");
    // All four channels complete at once.
    @(posedge pclk);
    tx_done_evt <= 4'hF;
    @(posedge pclk);
    tx_done_evt <= 4'h0;
    rdchk(`UDC_OFS_RAW, 32'h0000_000F, "raw flags");
    wr(`UDC_OFS_RAW, 32'h0000_0000);
    rdchk(`UDC_OFS_RAW, 32'h0000_000F, "raw read only");
    rdchk(`UDC_OFS_MASKED, 32'h0000_000C, "masked flags");
    chk("dma_irq on masked", {31'h0, dma_irq}, 32'h0000_0001);
    // A nonzero vector is stored but does not acknowledge.
    wr(`UDC_OFS_IRQ_ACK, 32'h0000_00A5);
    @(negedge pclk);
    chk("dma_irq nonzero vector", {31'h0, dma_irq}, 32'h0000_0001);
    rdchk(`UDC_OFS_IRQ_ACK, 32'h0000_00A5, "vector readback");
    // A zero vector acknowledges; the line returns while masked bits stay set.
    wr(`UDC_OFS_IRQ_ACK, 32'h0000_0000);
    @(negedge pclk);
    chk("dma_irq gap", {31'h0, dma_irq}, 32'h0000_0000);
    @(negedge pclk);
    chk("dma_irq again", {31'h0, dma_irq}, 32'h0000_0001);
    // The engine clears the raw flags, so the line falls and stays down after a zero vector.
    @(posedge pclk);
    tx_done_ack <= 4'hF;
    @(posedge pclk);
    tx_done_ack <= 4'h0;
    rdchk(`UDC_OFS_RAW, 32'h0000_0000, "raw cleared");
    rdchk(`UDC_OFS_MASKED, 32'h0000_0000, "masked cleared");
    wr(`UDC_OFS_IRQ_ACK, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    chk("dma_irq idle", {31'h0, dma_irq}, 32'h0000_0000);
    rdchk(`UDC_OFS_EVT_STAT, 32'h0000_001F, "events seen");
    // Descriptors are taken as ready before the receive DMA is turned on.
    wr(`UDC_OFS_RX_CTRL, 32'h0000_0001);
    @(negedge pclk);
    chk("rx on", {31'h0, rx_dma_on}, 32'h0000_0001);
    rdchk(`UDC_OFS_RX_CTRL, 32'h0000_0001, "rx control");
    wr(`UDC_OFS_RX_CTRL, 32'h0000_0000);
    @(negedge pclk);
    chk("rx off", {31'h0, rx_dma_on}, 32'h0000_0000);
    // A completion in the same cycle as its engine acknowledge wins and keeps the flag.
    @(posedge pclk);
    tx_done_evt <= 4'h1;
    tx_done_ack <= 4'h1;
    @(posedge pclk);
    tx_done_evt <= 4'h0;
    tx_done_ack <= 4'h0;
    rdchk(`UDC_OFS_RAW, 32'h0000_0001, "raw set wins");
    rdchk(`UDC_OFS_MASKED, 32'h0000_0000, "masked gated off");
    chk("dma_irq gated off", {31'h0, dma_irq}, 32'h0000_0000);
    // Enabling the pending channel raises the line one edge after the edge where the write commits.
    wr(`UDC_OFS_EN_SET, 32'h0000_0001);
    repeat (2) @(negedge pclk);
    chk("dma_irq after enable", {31'h0, dma_irq}, 32'h0000_0001);
    rdchk(`UDC_OFS_MASKED, 32'h0000_0001, "masked enabled");
    rdchk(`UDC_OFS_EVT_MASK, 32'h0000_0020, "event mask");
    rdchk(`UDC_OFS_EVT_STAT, 32'h0000_0001, "late event");
    conclude;
  end
endmodule

`default_nettype wire
